//--- verilog/bridge_timing_regs.vh
// Register map, field layout and timing constants of the bridge timing block.
`ifndef BRIDGE_TIMING_REGS_VH
`define BRIDGE_TIMING_REGS_VH

// ----------------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------------
`define FRAME_BITS        5'h10
`define FRAME_WR_BIT      15
`define FRAME_ADDR_HI     14
`define FRAME_ADDR_LO     11
`define FRAME_DATA_HI     10
`define FRAME_CFG_B_BIT   10

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_ENABLE       4'h0
`define ADDR_POLARITY     4'h1
`define ADDR_PWM_MODE     4'h2
`define ADDR_PWM_SOURCE   4'h3
`define ADDR_CAL          4'h4
`define ADDR_CFG_FIRST    4'h5
`define ADDR_CFG_LAST     4'h8
`define ADDR_DEGLITCH     4'he

// ----------------------------------------------------------------------
// Channel configuration A fields
// ----------------------------------------------------------------------
`define CFGA_BLANK_LO     8
`define CFGA_PCF_LO       5
`define CFGA_PCR_LO       2
`define CFGA_TPC_LO       0
// ----------------------------------------------------------------------
// Channel configuration B fields
// ----------------------------------------------------------------------
`define CFGB_VDS_LO       7
`define CFGB_DLY_LO       3
`define CFGB_SLEW_LO      0

// ----------------------------------------------------------------------
// Calibration control and result fields
// ----------------------------------------------------------------------
`define CAL_DELAY_SAMPLE_SEL_LO        7
`define CAL_PRECHARGE_SAMPLE_SEL_LO         3
`define CAL_SEL_OFF       3'h0
`define CAL_SEL_MAX       3'h4
`define RES_READY_BIT     8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS     50
`define BLANK_STEP_NS     250
`define PRECHARGE_STEP_NS 500
`define DELAY_STEP_NS     500
`define CAL_STEP_NS       100
`define TIMEOUT_NS        10000
`define BLANK_STEP_CYC    ((`BLANK_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRE_STEP_CYC      ((`PRECHARGE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DLY_STEP_CYC      ((`DELAY_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_STEP_CYC      ((`CAL_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMEOUT_CYC       (`TIMEOUT_NS / `CLK_PERIOD_NS)
`define CNT_MAX           12'hfff

`endif

//--- verilog/pulse_filter.v
// Symmetric de-glitch filter for one routed pulse input.
`timescale 1ns/1ns
module pulse_filter (
  input  wire        ref_clk,   // Block clock.
  input  wire        srst,      // Synchronous reset, active high.
  input  wire        raw_in,    // Routed pulse input level.
  input  wire [11:0] limit,     // Stable cycles needed before acceptance.
  input  wire        hold,      // Switching sequence still running.
  output reg         level_reg  // Accepted input level.
);

  reg [11:0] cnt_reg;

  // Both edge directions see the same count, so the filter is symmetric.
  always @(posedge ref_clk) begin
    if (srst) begin
      cnt_reg   <= 12'h000;
      level_reg <= 1'b0;
    end else if (raw_in == level_reg) begin
      cnt_reg <= 12'h000; // RULE25
    end else if (cnt_reg >= limit) begin
      if (!hold) begin
        level_reg <= raw_in; // RULE8
        cnt_reg   <= 12'h000;
      end
    end else begin
      cnt_reg <= cnt_reg + 12'h001; // RULE25
    end
  end

endmodule

//--- verilog/half_bridge_slope_timing.v
// Gate timing, input de-glitch and slope calibration for four half-bridges.
// Function
// [RULE1] Each bridge has a two-bit blanking time select.
// [RULE2] Each bridge holds three-bit rise and fall pre-charge current selects.
// [RULE3] Each bridge holds one two-bit pre-charge duration for both slopes.
// [RULE4] Each bridge holds a three-bit slew current select for both slopes.
// [RULE5] Each bridge holds a four-bit overload check delay select.
// [RULE6] Each bridge holds a three-bit overload comparator threshold select.
// [RULE7] In pulse mode the routed input gets an adaptive symmetric de-glitch.
// [RULE8] A started turn-on or turn-off sequence always completes.
// [RULE9] After timeout the high gate drops to its timeout current.
// [RULE10] Polarity-bit switching runs pre-charge and slew but skips de-glitch.
// [RULE11] Type bit 0 filters for blank plus pre-charge plus delay.
// [RULE12] Type bit 1 filters for pre-charge plus delay.
// [RULE13] Host sets de-glitch type before starting pulse drive.
// [RULE14] Host keeps duty ratio within the de-glitch derived bounds.
// [RULE15] High gate: pre-charge current, then slew until timeout, then hold.
// [RULE16] Low gate always uses a multiple of the slew current.
// [RULE17] Calibration samples the node via four comparators at set times.
// [RULE18] One cycle samples both slopes and stores two-bit codes each.
// [RULE19] Writing calibration control enables it; select, two sample fields.
// [RULE20] Select zero turns calibration off and ends a running one.
// [RULE21] Detection starts on next routed edge, ends after both slopes. Code ends it only after a slope repeats an already sampled direction.
// [RULE22] Ready is set after both slopes, cleared on read; repeat until set. Code sets it only after a slope repeats a sampled direction.
// [RULE23] Source bit picks the first input at 0 and second at 1.
// [RULE24] Input low: polarity driver off, other on; input high: reverse.
// [RULE25] De-glitch is a counter accepting a level after it stays stable.
`timescale 1ns/1ns
`include "bridge_timing_regs.vh"
module half_bridge_slope_timing (
  input  wire        ref_clk,                // Block clock, 20 MHz.
  input  wire        srst,                   // Synchronous reset, high.
  input  wire        spi_sclk,               // Serial clock, sampled.
  input  wire        spi_csb_n,              // Serial select, active low.
  input  wire        spi_mosi,               // Serial data in.
  output wire        spi_miso,               // Serial data out.
  output wire        spi_miso_oe,            // Serial out enable.
  input  wire [1:0]  pulse_input,            // Two external pulse inputs.
  input  wire [3:0]  cal_cmp,                // Comparators 5/15/85/95 pct.
  output wire [2:0]  cal_node_sel,           // Node mux select, 0 is off.
  output wire [3:0]  high_gate_out,          // High gate driven on.
  output wire [3:0]  low_gate_out,           // Low gate driven on.
  output wire [7:0]  high_gate_phase,        // 0 off 1 pre 2 slew 3 hold.
  output wire [11:0] high_gate_isel,         // High gate current code.
  output wire [11:0] low_gate_isel,          // Low gate slew code.
  output wire [7:0]  blank_time_sel,         // Blanking select per bridge.
  output wire [11:0] overload_threshold_sel, // Comparator threshold code.
  output wire [3:0]  overload_check          // Overload check window open.
);

  // --------------------------------------------------------------------
  // Channel and calibration state encoding
  // --------------------------------------------------------------------
  localparam ST_OFF   = 3'd0;
  localparam ST_BLANK = 3'd1;
  localparam ST_PRE   = 3'd2;
  localparam ST_SLEW  = 3'd3;
  localparam ST_HOLD  = 3'd4;
  localparam ST_LOW   = 3'd5;
  localparam CAL_IDLE = 2'd0;
  localparam CAL_WAIT = 2'd1;
  localparam CAL_RUN  = 2'd2;
  localparam CAL_DONE = 2'd3;

  // --------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------
  reg  [3:0]  enable_reg;
  reg  [3:0]  bridge_polarity_reg;
  reg  [3:0]  pwm_mode_reg;
  reg  [3:0]  pwm_source_reg;
  reg  [39:0] cfg_a_reg;
  reg  [39:0] cfg_b_reg;
  reg  [3:0]  deglitch_type_register;
  reg  [10:0] calibration_control;
  reg  [8:0]  calibration_result;
  reg  [1:0]  cal_state_reg;
  reg  [1:0]  cal_done_reg;
  reg         cal_rise_reg;
  reg         cal_prev_reg;
  reg  [11:0] cal_cnt_reg;
  reg         cal_wr_pulse;
  reg         cal_rd_pulse;

  // --------------------------------------------------------------------
  // Serial slave
  // --------------------------------------------------------------------
  reg         sclk_prev_reg;
  reg         csb_prev_reg;
  reg  [4:0]  bit_cnt_reg;
  reg  [15:0] rx_reg;
  reg  [15:0] tx_reg;
  reg  [10:0] rd_data;
  wire        sclk_rise = spi_sclk & ~sclk_prev_reg;
  wire        sclk_fall = ~spi_sclk & sclk_prev_reg;
  wire        frame_end = spi_csb_n & ~csb_prev_reg &
                          (bit_cnt_reg == `FRAME_BITS);
  wire        frame_wr  = rx_reg[`FRAME_WR_BIT];
  wire [3:0]  frame_addr = rx_reg[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
  wire [10:0] frame_data = rx_reg[`FRAME_DATA_HI:0];
  wire [1:0]  frame_ch   = frame_addr[1:0] - 2'h1;
  wire        frame_cfg  = (frame_addr >= `ADDR_CFG_FIRST) &&
                           (frame_addr <= `ADDR_CFG_LAST);

  assign spi_miso    = tx_reg[15];
  assign spi_miso_oe = ~spi_csb_n;

  always @* begin
    rd_data = 11'h000;
    case (frame_addr)
      `ADDR_ENABLE:     rd_data = {7'h00, enable_reg};
      `ADDR_POLARITY:   rd_data = {7'h00, bridge_polarity_reg};
      `ADDR_PWM_MODE:   rd_data = {7'h00, pwm_mode_reg};
      `ADDR_PWM_SOURCE: rd_data = {7'h00, pwm_source_reg};
      `ADDR_DEGLITCH:   rd_data = {7'h00, deglitch_type_register};
      `ADDR_CAL:
        if (frame_wr) begin
          rd_data = calibration_control;
        end else begin
          rd_data = {2'h0, calibration_result};
        end
      default:
        if (frame_cfg && frame_data[`FRAME_CFG_B_BIT]) begin
          rd_data = {1'b1, cfg_b_reg[frame_ch*10 +: 10]};
        end else if (frame_cfg) begin
          rd_data = {1'b0, cfg_a_reg[frame_ch*10 +: 10]};
        end else begin
          rd_data = 11'h000;
        end
    endcase
  end

  // The answer to a frame is shifted out during the following frame.
  always @(posedge ref_clk) begin
    if (srst) begin
      sclk_prev_reg <= 1'b0;
      csb_prev_reg  <= 1'b1;
      bit_cnt_reg   <= 5'h00;
      rx_reg        <= 16'h0000;
      tx_reg        <= 16'h0000;
    end else begin
      sclk_prev_reg <= spi_sclk;
      csb_prev_reg  <= spi_csb_n;
      if (spi_csb_n) begin
        bit_cnt_reg <= 5'h00;
      end else if (sclk_rise) begin
        rx_reg <= {rx_reg[14:0], spi_mosi};
        if (bit_cnt_reg != `FRAME_BITS) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end else if (sclk_fall) begin
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
      if (frame_end) begin
        tx_reg <= {frame_addr, 1'b0, rd_data};
      end
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      enable_reg             <= 4'h0;
      bridge_polarity_reg    <= 4'h0;
      pwm_mode_reg           <= 4'h0;
      pwm_source_reg         <= 4'h0;
      cfg_a_reg              <= 40'h00_0000_0000;
      cfg_b_reg              <= 40'h00_0000_0000;
      deglitch_type_register <= 4'h0;
      calibration_control    <= 11'h000; // RULE20
      cal_wr_pulse           <= 1'b0;
      cal_rd_pulse           <= 1'b0;
    end else begin
      cal_wr_pulse <= frame_end && frame_wr && (frame_addr == `ADDR_CAL);
      cal_rd_pulse <= frame_end && !frame_wr && (frame_addr == `ADDR_CAL);
      if (frame_end && frame_wr) begin
        case (frame_addr)
          `ADDR_ENABLE:     enable_reg <= frame_data[3:0];
          `ADDR_POLARITY:   bridge_polarity_reg <= frame_data[3:0];
          `ADDR_PWM_MODE:   pwm_mode_reg <= frame_data[3:0];
          `ADDR_PWM_SOURCE: pwm_source_reg <= frame_data[3:0]; // RULE23
          `ADDR_DEGLITCH:   deglitch_type_register <= frame_data[3:0];
          `ADDR_CAL:        calibration_control <= frame_data; // RULE19
          default:
            if (frame_cfg && frame_data[`FRAME_CFG_B_BIT]) begin
              cfg_b_reg[frame_ch*10 +: 10] <= frame_data[9:0]; // RULE4
            end else if (frame_cfg) begin
              cfg_a_reg[frame_ch*10 +: 10] <= frame_data[9:0]; // RULE2
            end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Per-bridge timing
  // --------------------------------------------------------------------
  wire [3:0] routed_in;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : bridge
      wire [9:0]  cfg_a   = cfg_a_reg[ch*10 +: 10];
      wire [9:0]  cfg_b   = cfg_b_reg[ch*10 +: 10];
      wire [1:0]  blank   = cfg_a[`CFGA_BLANK_LO +: 2]; // RULE1
      wire [2:0]  pc_fall = cfg_a[`CFGA_PCF_LO +: 3];
      wire [2:0]  pc_rise = cfg_a[`CFGA_PCR_LO +: 3];   // RULE2
      wire [1:0]  tpc     = cfg_a[`CFGA_TPC_LO +: 2];   // RULE3
      wire [3:0]  dly     = cfg_b[`CFGB_DLY_LO +: 4];   // RULE5
      wire [2:0]  slew    = cfg_b[`CFGB_SLEW_LO +: 3];  // RULE4
      wire [31:0] blank_w = (blank + 1) * `BLANK_STEP_CYC;
      wire [31:0] pre_w   = (tpc + 1) * `PRE_STEP_CYC;
      wire [31:0] dly_w   = (dly + 1) * `DLY_STEP_CYC;
      wire [11:0] blank_c = blank_w[11:0];
      wire [11:0] pre_c   = pre_w[11:0];
      wire [11:0] dly_c   = dly_w[11:0];
      wire [11:0] limit;
      wire        filt;
      wire        busy;
      wire        want_high;
      reg  [2:0]  st_reg;
      reg         dir_reg;
      reg  [11:0] cnt_reg;

      assign limit = deglitch_type_register[ch] ?
                     pre_c + dly_c :                  // RULE12
                     blank_c + pre_c + dly_c;         // RULE11
      assign routed_in[ch] = pulse_input[pwm_source_reg[ch]]; // RULE23
      assign busy = (st_reg == ST_BLANK) || (st_reg == ST_PRE);

      pulse_filter u_filter (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .raw_in    (routed_in[ch]), // RULE7
        .limit     (limit),
        .hold      (busy),          // RULE8
        .level_reg (filt)
      );

      // Without pulse mode the polarity bit alone picks the side.
      assign want_high = pwm_mode_reg[ch] ?
                         ~(filt ^ bridge_polarity_reg[ch]) : // RULE24
                         bridge_polarity_reg[ch];            // RULE10

      always @(posedge ref_clk) begin
        if (srst || !enable_reg[ch]) begin
          st_reg  <= ST_OFF;
          dir_reg <= 1'b0;
          cnt_reg <= 12'h000;
        end else begin
          if (cnt_reg != `CNT_MAX) begin
            cnt_reg <= cnt_reg + 12'h001;
          end
          case (st_reg)
            ST_OFF: begin
              dir_reg <= want_high;
              st_reg  <= ST_BLANK;
              cnt_reg <= 12'h000;
            end
            ST_BLANK:
              if (cnt_reg + 12'h001 >= blank_c) begin
                st_reg  <= dir_reg ? ST_PRE : ST_LOW;
                cnt_reg <= 12'h000;
              end
            ST_PRE:
              if (cnt_reg + 12'h001 >= pre_c) begin // RULE15
                st_reg  <= dir_reg ? ST_SLEW : ST_BLANK;
                cnt_reg <= 12'h000;
              end
            ST_SLEW:
              if (cnt_reg + 12'h001 >= `TIMEOUT_CYC) begin
                st_reg <= ST_HOLD; // RULE9
              end else if (!want_high) begin
                dir_reg <= 1'b0;
                st_reg  <= ST_PRE;
                cnt_reg <= 12'h000;
              end
            ST_HOLD:
              if (!want_high) begin
                dir_reg <= 1'b0;
                st_reg  <= ST_PRE;
                cnt_reg <= 12'h000;
              end
            ST_LOW:
              if (want_high) begin
                dir_reg <= 1'b1;
                st_reg  <= ST_BLANK;
                cnt_reg <= 12'h000;
              end
            default: st_reg <= ST_OFF;
          endcase
        end
      end

      assign high_gate_out[ch] = dir_reg && ((st_reg == ST_PRE) ||
                                 (st_reg == ST_SLEW) || (st_reg == ST_HOLD));
      assign low_gate_out[ch]  = (st_reg == ST_LOW);
      assign high_gate_phase[ch*2 +: 2] =
        (st_reg == ST_PRE)  ? 2'h1 :
        (st_reg == ST_SLEW) ? 2'h2 :
        (st_reg == ST_HOLD) ? 2'h3 : 2'h0; // RULE15
      assign high_gate_isel[ch*3 +: 3] = (st_reg == ST_PRE) ?
        (dir_reg ? pc_rise : pc_fall) : slew; // RULE15
      assign low_gate_isel[ch*3 +: 3] = slew; // RULE16
      assign blank_time_sel[ch*2 +: 2] = blank;
      assign overload_threshold_sel[ch*3 +: 3] =
        cfg_b[`CFGB_VDS_LO +: 3]; // RULE6
      assign overload_check[ch] = ((st_reg == ST_SLEW) ||
        (st_reg == ST_HOLD) || (st_reg == ST_LOW)) &&
        (cnt_reg >= dly_c); // RULE5
    end
  endgenerate

  // --------------------------------------------------------------------
  // Slope calibration
  // --------------------------------------------------------------------
  wire [2:0]  cal_sel  = calibration_control[2:0];
  wire        cal_on   = (cal_sel != `CAL_SEL_OFF) &&
                         (cal_sel <= `CAL_SEL_MAX);
  wire [1:0]  cal_ch   = cal_sel[1:0] - 2'h1;
  wire        cal_in   = routed_in[cal_ch];
  wire [3:0]  pc_sel   = calibration_control[`CAL_PRECHARGE_SAMPLE_SEL_LO +: 4];
  wire [3:0]  dl_sel   = calibration_control[`CAL_DELAY_SAMPLE_SEL_LO +: 4];
  wire [31:0] cal_precharge_sample_sel_w = (pc_sel + 1) * `CAL_STEP_CYC;
  wire [31:0] cal_dl_w = (dl_sel + 1) * `CAL_STEP_CYC;
  wire [11:0] cal_precharge_sample_sel_c = cal_precharge_sample_sel_w[11:0];
  wire [11:0] cal_dl_c = cal_dl_w[11:0];
  wire [11:0] cal_end  = (cal_precharge_sample_sel_c > cal_dl_c) ? cal_precharge_sample_sel_c : cal_dl_c;
  wire [1:0]  low_sum  = {1'b0, cal_cmp[0]} + {1'b0, cal_cmp[1]} +
                         {1'b0, cal_cmp[2]};
  wire [1:0]  high_sum = {1'b0, cal_cmp[1]} + {1'b0, cal_cmp[2]} +
                         {1'b0, cal_cmp[3]};
  wire        cal_edge = cal_in ^ cal_prev_reg;
  wire        finish   = (cal_state_reg == CAL_RUN) &&
                         (cal_cnt_reg == cal_end) &&
                         (cal_rise_reg ? cal_done_reg[1] : cal_done_reg[0]);

  assign cal_node_sel = cal_on ? cal_sel : `CAL_SEL_OFF; // RULE17

  always @(posedge ref_clk) begin
    if (srst) begin
      cal_state_reg      <= CAL_IDLE;
      cal_done_reg       <= 2'h0;
      cal_rise_reg       <= 1'b0;
      cal_prev_reg       <= 1'b0;
      cal_cnt_reg        <= 12'h000;
      calibration_result <= 9'h000;
    end else begin
      cal_prev_reg <= cal_in;
      if (cal_rd_pulse && !finish) begin
        calibration_result[`RES_READY_BIT] <= 1'b0; // RULE22
      end
      if (cal_wr_pulse || !cal_on) begin
        cal_state_reg <= cal_on ? CAL_WAIT : CAL_IDLE; // RULE20
        cal_done_reg  <= 2'h0;
        calibration_result[`RES_READY_BIT] <= 1'b0;
      end else begin
        case (cal_state_reg)
          CAL_WAIT:
            if (cal_edge) begin // RULE21
              cal_rise_reg  <= ~(cal_in ^ bridge_polarity_reg[cal_ch]);
              cal_cnt_reg   <= 12'h001;
              cal_state_reg <= CAL_RUN;
            end
          CAL_RUN: begin
            cal_cnt_reg <= cal_cnt_reg + 12'h001;
            if (cal_cnt_reg == cal_precharge_sample_sel_c) begin // RULE17
              if (cal_rise_reg) begin
                calibration_result[5:4] <= low_sum;
              end else begin
                calibration_result[1:0] <= 2'h3 - high_sum;
              end
            end
            if (cal_cnt_reg == cal_dl_c) begin
              if (cal_rise_reg) begin
                calibration_result[7:6] <= high_sum;
              end else begin
                calibration_result[3:2] <= 2'h3 - low_sum;
              end
            end
            if (cal_cnt_reg == cal_end) begin
              cal_done_reg[cal_rise_reg] <= 1'b1; // RULE18
              if (finish) begin
                calibration_result[`RES_READY_BIT] <= 1'b1; // RULE22
                cal_state_reg <= CAL_DONE;
              end else begin
                cal_state_reg <= CAL_WAIT;
              end
            end
          end
          CAL_DONE:
            if (!calibration_result[`RES_READY_BIT]) begin
              cal_done_reg  <= 2'h0;
              cal_state_reg <= CAL_WAIT;
            end
          default: cal_state_reg <= cal_on ? CAL_WAIT : CAL_IDLE;
        endcase
      end
    end
  end

endmodule

//--- verification/half_bridge_slope_timing_monitor.sv
// Assertion checker on the ports of the bridge timing block.
`timescale 1ns/1ns
module half_bridge_slope_timing_monitor (
  input wire        ref_clk,         // Clock.
  input wire        srst,            // Reset.
  input wire [2:0]  cal_node_sel,    // Node select.
  input wire [3:0]  high_gate_out,   // High gates.
  input wire [3:0]  low_gate_out,    // Low gates.
  input wire [7:0]  high_gate_phase, // Phases.
  input wire [11:0] high_gate_isel,  // High codes.
  input wire [11:0] low_gate_isel,   // Low codes.
  input wire [3:0]  overload_check   // Check windows.
);
  wire [1:0] ph0 = high_gate_phase[1:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Shortest settings still give ten pre-charge and fifteen off cycles.
  sequence pre_run;
    (ph0 == 2'd1) [*8];
  endsequence
  sequence low_held_off;
    !low_gate_out[0] [*8];
  endsequence
  gates_apart_a:
    assert property ((high_gate_out & low_gate_out) == 4'h0)
    else $error("both gates on");
  hold_after_slew_a:
    assert property ($rose(ph0 == 2'd3) |-> $past(ph0) == 2'd2)
    else $error("hold without slew");
  low_uses_slew_a:
    assert property (ph0 != 2'd1 |->
      low_gate_isel[2:0] == high_gate_isel[2:0]) else $error("low code off");
  pre_min_a:
    assert property ($rose(ph0 == 2'd1) |-> pre_run)
    else $error("pre-charge too short");
  blank_gap_a:
    assert property ($fell(high_gate_out[0]) |-> low_held_off)
    else $error("low gate too early");
  cal_range_a:
    assert property (cal_node_sel <= 3'h4)
    else $error("bad node select");
  check_on_gate_a:
    assert property (overload_check[0] |-> high_gate_out[0] | low_gate_out[0])
    else $error("check with gates off");
  check_delay_a:
    assert property ($rose(overload_check[0]) |->
      $past(high_gate_out[0] | low_gate_out[0], 9)) else $error("check early");
endmodule
bind half_bridge_slope_timing half_bridge_slope_timing_monitor u_monitor (
  .ref_clk(ref_clk), .srst(srst), .cal_node_sel(cal_node_sel),
  .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
  .high_gate_phase(high_gate_phase), .high_gate_isel(high_gate_isel),
  .low_gate_isel(low_gate_isel), .overload_check(overload_check));

//--- verification/spi_host.sv
// Serial host model sending sixteen-bit register frames.
`timescale 1ns/1ns
module spi_host (
  input  wire ref_clk, // Pacing clock.
  input  wire miso,    // Data from block.
  output reg  sclk,    // Serial clock, idle low.
  output reg  csb_n,   // Frame select.
  output reg  mosi     // Data to block.
);
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    mosi = 1'b0;
  end
  // Three clocks per half period, since the block samples the serial clock.
  task xfer(input [15:0] d, output [15:0] rsp);
    integer i;
    begin
      @(posedge ref_clk) #5 csb_n = 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        mosi = d[i];
        repeat (3) @(posedge ref_clk);
        #5 sclk = 1'b1;
        rsp[i] = miso;
        repeat (3) @(posedge ref_clk);
        #5 sclk = 1'b0;
      end
      repeat (3) @(posedge ref_clk);
      #5 csb_n = 1'b1;
      mosi = ~mosi;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule

//--- verification/testbench.sv
// Self-checking bench for the bridge timing block.
`timescale 1ns/1ns
module testbench;
  reg         ref_clk = 1'b0;
  reg         srst, src, hit;
  reg  [1:0]  pulse_input;
  reg  [3:0]  cal_cmp, a;
  reg  [15:0] r;
  reg  [9:0]  ca, cb;
  reg  [2:0]  c;
  integer     num_errors, comparisons, seed, i, lim;
  wire        spi_sclk, spi_csb_n, spi_mosi, spi_miso;
  wire [2:0]  cal_node_sel;
  wire [3:0]  high_gate_out, low_gate_out, overload_check;
  wire [7:0]  high_gate_phase, blank_time_sel;
  wire [11:0] high_gate_isel, low_gate_isel, overload_threshold_sel;
  always #25 ref_clk = ~ref_clk;
  half_bridge_slope_timing u_half_bridge_slope_timing (
    .ref_clk(ref_clk), .srst(srst), .spi_sclk(spi_sclk),
    .spi_csb_n(spi_csb_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(), .pulse_input(pulse_input), .cal_cmp(cal_cmp),
    .cal_node_sel(cal_node_sel), .high_gate_out(high_gate_out),
    .low_gate_out(low_gate_out), .high_gate_phase(high_gate_phase),
    .high_gate_isel(high_gate_isel), .low_gate_isel(low_gate_isel),
    .blank_time_sel(blank_time_sel), .overload_check(overload_check),
    .overload_threshold_sel(overload_threshold_sel));
  spi_host u_spi_host (.ref_clk(ref_clk), .miso(spi_miso), .sclk(spi_sclk),
    .csb_n(spi_csb_n), .mosi(spi_mosi));
  task check(input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] ad, input [10:0] d);
    u_spi_host.xfer({1'b1, ad, d}, r);
  endtask
  // The answer to a read only comes out during the following frame.
  task rd(input [3:0] ad, input b);
    begin
      u_spi_host.xfer({1'b0, ad, b, 10'h000}, r);
      u_spi_host.xfer(16'h0000, r);
    end
  endtask
  task run(input integer n, input lv);
    integer j;
    for (j = 0; j < n; j = j + 1) begin
      @(posedge ref_clk);
      #5 pulse_input[src] = lv;
      pulse_input[!src] = $random(seed);
      hit = hit | high_gate_out[0];
    end
  endtask
  function integer flt_len(input [1:0] b, input [1:0] t, input [3:0] d,
    input ty);
    flt_len = (ty ? 0 : (b + 1) * 5) + (t + 1) * 10 + (d + 1) * 10;
  endfunction
  function [8:0] cal_res(input [2:0] k);
    reg [1:0] lo, hi;
    begin
      hi = (k > 3) ? 2'h3 : k[1:0];
      lo = (k == 0) ? 2'h0 : k[1:0] - 2'h1;
      cal_res = {1'b1, lo, hi, 2'h3 - hi, 2'h3 - lo};
    end
  endfunction
  task conclude;
    begin
      if (num_errors == 0 && comparisons > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #2_000_000;
    num_errors = num_errors + 1;
    conclude;
  end
  initial begin
    seed = 32'h554eb225;
    num_errors = 0;
    comparisons = 0;
    srst = 1'b1;
    src = 1'b0;
    hit = 1'b0;
    pulse_input = 2'h0;
    cal_cmp = 4'h0;
    repeat (8) @(posedge ref_clk);
    #5 srst = 1'b0;
    for (a = 4'h8; a > 4'h4; a = a - 4'h1) begin
      ca = $random(seed);
      cb = $random(seed);
      wr(a, {1'b0, ca});
      wr(a, {1'b1, cb});
      rd(a, 1'b0);
      check(r, {a, 2'b00, ca});
      rd(a, 1'b1);
      check(r, {a, 2'b01, cb});
      check(blank_time_sel[2 * (a - 4'h5) +: 2], ca[9:8]);
      check(overload_threshold_sel[3 * (a - 4'h5) +: 3], cb[9:7]);
    end
    wr(4'h9, 11'h7ff);
    rd(4'h9, 1'b0);
    check(r, 16'h9000);
    wr(4'h1, 11'h001);
    wr(4'h0, 11'h001);
    run(400, 1'b0);
    check(high_gate_phase[1:0], 2'd3);
    check({high_gate_out[0], low_gate_out[0]}, 2'b10);
    wr(4'h1, 11'h000);
    run(100, 1'b0);
    check({high_gate_out[0], low_gate_out[0]}, 2'b01);
    for (i = 0; i < 2; i = i + 1) begin
      src = i[0];
      wr(4'h2, 11'h000);
      wr(4'he, {10'h000, i[0]});
      wr(4'h3, {10'h000, i[0]});
      wr(4'h1, 11'h001);
      wr(4'h2, 11'h001);
      lim = flt_len(ca[9:8], ca[1:0], cb[6:3], i[0]);
      run(lim + 100, 1'b0);
      hit = 1'b0;
      run(lim - 2, 1'b1);
      run(lim + 60, 1'b0);
      check(hit, 1'b0);
      run(lim + 70, 1'b1);
      check(high_gate_out[0], 1'b1);
    end
    c = {$random(seed)} % 5;
    cal_cmp = (4'h1 << c) - 4'h1;
    wr(4'h4, {cb[7:0], 3'h1});
    check(cal_node_sel, 3'h1);
    run(400, 1'b0);
    run(400, 1'b1);
    run(400, 1'b0);
    rd(4'h4, 1'b0);
    check(r, {4'h4, 3'h0, cal_res(c)});
    rd(4'h4, 1'b0);
    check(r[8], 1'b0);
    wr(4'h4, 11'h000);
    check(cal_node_sel, 3'h0);
    conclude;
  end
endmodule
